// file: common/sfp_pkg.sv
// Constants and types shared by the synchronous FIFO port and flag logic.
// Assumes a single clock domain; the read and write ports share CLK.
package sfp_pkg;

    // Word width of the input and output buses
    localparam int unsigned DATA_W         = 9;
    // Default storage depth and pointer width
    localparam int unsigned DEPTH_DEFAULT  = 64;
    localparam int unsigned ADDR_W_DEFAULT = 6;
    // Offset loaded into both programmable flags at master reset
    localparam int unsigned OFFSET_DEFAULT = 7;
    // Pin mode held after master reset: high means dual write enable
    localparam logic        MODE_DUAL      = 1'b1;
    localparam logic        MODE_PROG      = 1'b0;

    // Which offset the next offset access touches (one-hot)
    typedef enum logic [1:0] {
        SEL_EMPTY = 2'b01,
        SEL_FULL  = 2'b10
    } sfp_sel_t;

endpackage : sfp_pkg

// file: hw/sfp_mem.sv
// Word storage for the FIFO: one write port, one asynchronous read port.
// Assumes the caller only writes when a slot is free and gates with CE.
`timescale 1ns/1ps
module sfp_mem #(
    parameter int unsigned DEPTH  = sfp_pkg::DEPTH_DEFAULT,
    parameter int unsigned ADDR_W = sfp_pkg::ADDR_W_DEFAULT
) (
    // Clock
    input  wire logic                       clk,
    // Write side
    input  wire logic                       wr_en,
    input  wire logic [ADDR_W-1:0]          wr_addr,
    input  wire logic [sfp_pkg::DATA_W-1:0] wr_data,
    // Read side
    input  wire logic [ADDR_W-1:0]          rd_addr,
    output logic      [sfp_pkg::DATA_W-1:0] rd_data
);

    // Storage array; no reset so it can map onto RAM
    logic [sfp_pkg::DATA_W-1:0] mem [DEPTH];

    // Write one word per enabled edge
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read is combinational; the top registers it onto the pins
    assign rd_data = mem[rd_addr];

endmodule : sfp_mem

// file: hw/sfp_fifo.sv
// Synchronous 9-bit FIFO with dual-enable write port, dual-enable read
// port, output enable, and fixed plus programmable flags.
// Assumes all pin inputs are synchronous to CLK; the bus three-state is
// resolved outside from OUT_BUS_OE.
//
// What this block does
// - Load pin high at master reset: second enable
// - Load pin low at reset: offset access control
// - Dual mode: store when enable A low, B high
// - No store while full flag low
// - Output one word when both read enables low
// - No read, pointer held, while empty flag low
// - Drive output bus while output enable low, one edge after the pin
// - Empty flag low when nothing stored
// - Almost-empty low within offset of empty, default 7
// - Almost-full low within offset of full, default 7
// - Full flag low when every location holds data
// - Master reset: pointers zero, flags to reset levels
// - Flag mode: enable A alone qualifies writes
`timescale 1ns/1ps
module sfp_fifo #(
    parameter int unsigned DEPTH  = sfp_pkg::DEPTH_DEFAULT,
    parameter int unsigned ADDR_W = sfp_pkg::ADDR_W_DEFAULT
) (
    // Clock, reset, enable
    input  wire logic                       CLK,
    input  wire logic                       RESETN,
    input  wire logic                       CE,
    // Master reset pin, active low, synchronous
    input  wire logic                       MASTER_RESET_N,
    // Write port
    input  wire logic [sfp_pkg::DATA_W-1:0] IN_BUS,
    input  wire logic                       WRITE_ENABLE_A_N,
    input  wire logic                       WRITE_ENABLE_B_OR_OFFSET_LOAD,
    // Read port
    input  wire logic                       READ_ENABLE_A_N,
    input  wire logic                       READ_ENABLE_B_N,
    input  wire logic                       OUTPUT_ENABLE_N,
    output logic      [sfp_pkg::DATA_W-1:0] OUT_BUS,
    output logic                            OUT_BUS_OE,
    // Flags, all active low
    output logic                            EMPTY_FLAG_N,
    output logic                            ALMOST_EMPTY_FLAG_N,
    output logic                            ALMOST_FULL_FLAG_N,
    output logic                            FULL_FLAG_N,
    // Pin mode chosen at the last master reset
    output logic                            DUAL_ENABLE_MODE
);

    // Count width holds 0..DEPTH inclusive
    localparam int unsigned CNT_W = ADDR_W + 1;
    // Local copy of the word width so a size cast can name it plainly
    localparam int unsigned DW    = sfp_pkg::DATA_W;

    // Wrap-around pointer advance, shared by both ports
    function automatic logic [ADDR_W-1:0] inc_ptr(input logic [ADDR_W-1:0] p);
        if (p == ADDR_W'(DEPTH - 1))
        begin
            return '0;
        end
        return ADDR_W'(p + ADDR_W'(1));
    endfunction : inc_ptr

    logic [ADDR_W-1:0]          wr_ptr;       // Next slot to fill
    logic [ADDR_W-1:0]          rd_ptr;       // Oldest stored word
    logic [CNT_W-1:0]           count;        // Words stored
    logic [CNT_W-1:0]           next_count;   // Count after this edge
    logic [ADDR_W-1:0]          offset_empty; // Almost-empty offset
    logic [ADDR_W-1:0]          offset_full;  // Almost-full offset
    sfp_pkg::sfp_sel_t          wr_sel;       // Offset the next load writes
    sfp_pkg::sfp_sel_t          rd_sel;       // Offset the next readback shows
    logic                       mode;         // Dual enable or flag mode
    logic                       offset_sel;   // Load pin low in flag mode
    logic                       write_req;    // Producer asks to store
    logic                       write_do;     // Store really happens
    logic                       read_req;     // Consumer asks for a word
    logic                       read_do;      // Read really happens
    logic                       offset_wr;    // Offset load this edge
    logic                       offset_rd;    // Offset readback this edge
    logic [sfp_pkg::DATA_W-1:0] mem_rd_data;  // Word at the read pointer

    // Decode the enables according to the latched mode
    always_comb
    begin
        offset_sel = (mode == sfp_pkg::MODE_PROG) && !WRITE_ENABLE_B_OR_OFFSET_LOAD;
        if (mode == sfp_pkg::MODE_DUAL)
        begin
            // Both enables must agree before a word is stored
            write_req = !WRITE_ENABLE_A_N && WRITE_ENABLE_B_OR_OFFSET_LOAD;
        end
        else
        begin
            // Enable A alone; the load pin steals the cycle for offsets
            write_req = !WRITE_ENABLE_A_N && !offset_sel;
        end
        offset_wr = !WRITE_ENABLE_A_N && offset_sel;
        read_req  = !READ_ENABLE_A_N && !READ_ENABLE_B_N && !offset_sel;
        offset_rd = !READ_ENABLE_A_N && !READ_ENABLE_B_N && offset_sel;
        // Registered flags gate the requests, so a full FIFO ignores the write
        // and an empty FIFO ignores the read on this edge
        write_do  = write_req && FULL_FLAG_N;
        read_do   = read_req && EMPTY_FLAG_N;
    end

    // Count after this edge; simultaneous read and write cancel
    always_comb
    begin
        next_count = count;
        if (write_do && !read_do)
        begin
            next_count = CNT_W'(count + CNT_W'(1));
        end
        else if (read_do && !write_do)
        begin
            next_count = CNT_W'(count - CNT_W'(1));
        end
    end

    // Mode capture: the pin is sampled on every edge of master reset so
    // the level seen at release is the one kept
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            mode <= sfp_pkg::MODE_DUAL;
        end
        else if (CE && !MASTER_RESET_N)
        begin
            mode <= WRITE_ENABLE_B_OR_OFFSET_LOAD;
        end
    end

    // Mode status output mirrors the latched mode
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            DUAL_ENABLE_MODE <= sfp_pkg::MODE_DUAL;
        end
        else if (CE)
        begin
            DUAL_ENABLE_MODE <= mode;
        end
    end

    // Pointers and word count
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else if (CE)
        begin
            if (!MASTER_RESET_N)
            begin
                // Both pointers back to the first location
                wr_ptr <= '0;
                rd_ptr <= '0;
                count  <= '0;
            end
            else
            begin
                if (write_do)
                begin
                    wr_ptr <= inc_ptr(wr_ptr);
                end
                if (read_do)
                begin
                    rd_ptr <= inc_ptr(rd_ptr);
                end
                count <= next_count;
            end
        end
    end

    // Offset loads alternate empty then full, starting over at reset
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            offset_empty <= ADDR_W'(sfp_pkg::OFFSET_DEFAULT);
            offset_full  <= ADDR_W'(sfp_pkg::OFFSET_DEFAULT);
            wr_sel       <= sfp_pkg::SEL_EMPTY;
        end
        else if (CE)
        begin
            if (!MASTER_RESET_N)
            begin
                offset_empty <= ADDR_W'(sfp_pkg::OFFSET_DEFAULT);
                offset_full  <= ADDR_W'(sfp_pkg::OFFSET_DEFAULT);
                wr_sel       <= sfp_pkg::SEL_EMPTY;
            end
            else if (offset_wr)
            begin
                unique case (wr_sel)
                    sfp_pkg::SEL_EMPTY:
                    begin
                        offset_empty <= IN_BUS[ADDR_W-1:0];
                        wr_sel       <= sfp_pkg::SEL_FULL;
                    end
                    sfp_pkg::SEL_FULL:
                    begin
                        offset_full <= IN_BUS[ADDR_W-1:0];
                        wr_sel      <= sfp_pkg::SEL_EMPTY;
                    end
                endcase
            end
        end
    end

    // Readback selector, independent of the load selector
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rd_sel <= sfp_pkg::SEL_EMPTY;
        end
        else if (CE)
        begin
            if (!MASTER_RESET_N)
            begin
                rd_sel <= sfp_pkg::SEL_EMPTY;
            end
            else if (offset_rd)
            begin
                rd_sel <= (rd_sel == sfp_pkg::SEL_EMPTY) ? sfp_pkg::SEL_FULL
                                                         : sfp_pkg::SEL_EMPTY;
            end
        end
    end

    // Output data register; holds its word between reads
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            OUT_BUS <= '0;
        end
        else if (CE)
        begin
            if (read_do)
            begin
                OUT_BUS <= mem_rd_data;
            end
            else if (offset_rd)
            begin
                // Offsets read back zero-extended in the low bits
                OUT_BUS <= (rd_sel == sfp_pkg::SEL_EMPTY)
                         ? DW'(offset_empty)
                         : DW'(offset_full);
            end
        end
    end

    // Output enable follows the pin one edge later, like the data
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            OUT_BUS_OE <= 1'b0;
        end
        else if (CE)
        begin
            OUT_BUS_OE <= !OUTPUT_ENABLE_N;
        end
    end

    // Flags from the count after this edge, so they never lag a transfer
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            EMPTY_FLAG_N        <= 1'b0;
            ALMOST_EMPTY_FLAG_N <= 1'b0;
            ALMOST_FULL_FLAG_N  <= 1'b1;
            FULL_FLAG_N         <= 1'b1;
        end
        else if (CE)
        begin
            if (!MASTER_RESET_N)
            begin
                EMPTY_FLAG_N        <= 1'b0;
                ALMOST_EMPTY_FLAG_N <= 1'b0;
                ALMOST_FULL_FLAG_N  <= 1'b1;
                FULL_FLAG_N         <= 1'b1;
            end
            else
            begin
                EMPTY_FLAG_N        <= (next_count != '0);
                ALMOST_EMPTY_FLAG_N <= !(next_count <= CNT_W'(offset_empty));
                ALMOST_FULL_FLAG_N  <= !(next_count >= CNT_W'(DEPTH - offset_full));
                FULL_FLAG_N         <= (next_count != CNT_W'(DEPTH));
            end
        end
    end

    // Storage; writes are already gated by the full flag and CE
    sfp_mem #(
        .DEPTH  (DEPTH),
        .ADDR_W (ADDR_W)
    ) u_mem (
        .clk     (CLK),
        .wr_en   (CE && MASTER_RESET_N && write_do),
        .wr_addr (wr_ptr),
        .wr_data (IN_BUS),
        .rd_addr (rd_ptr),
        .rd_data (mem_rd_data)
    );

endmodule : sfp_fifo

// file: verification/sfp_bus_model.sv
// Consumer-side view of the three-state output bus of the FIFO.
// Assumes OUT_BUS_OE high means the FIFO drives the bus.
`timescale 1ns/1ps
module sfp_bus_model (
    // Clock
    input  wire logic                       clk,
    // FIFO output side
    input  wire logic [sfp_pkg::DATA_W-1:0] out_bus,
    input  wire logic                       out_bus_oe,
    // Resolved bus level as the consumer sees it
    output logic      [sfp_pkg::DATA_W-1:0] bus_line
);
    logic [sfp_pkg::DATA_W-1:0] last; // Last driven value

    // Remember the last driven word
    always_ff @(posedge clk)
    begin
        if (out_bus_oe)
        begin
            last <= out_bus;
        end
    end

    // No pull on this bus: a released bus shows the inverse, never a stale match
    assign bus_line = out_bus_oe ? out_bus : ~last;
endmodule : sfp_bus_model

// file: verification/sfp_fifo_assertions.sv
// Concurrent checks on the FIFO pins.
// Assumes binding into sfp_fifo; sees its ports only.
`timescale 1ns/1ps
module sfp_fifo_assertions (
    // Clock and resets
    input  wire logic                       CLK,
    input  wire logic                       RESETN,
    input  wire logic                       CE,
    input  wire logic                       MASTER_RESET_N,
    // Controls
    input  wire logic                       WRITE_ENABLE_A_N,
    input  wire logic                       WRITE_ENABLE_B_OR_OFFSET_LOAD,
    input  wire logic                       READ_ENABLE_A_N,
    input  wire logic                       READ_ENABLE_B_N,
    input  wire logic                       OUTPUT_ENABLE_N,
    // Outputs
    input  wire logic [sfp_pkg::DATA_W-1:0] OUT_BUS,
    input  wire logic                       OUT_BUS_OE,
    input  wire logic                       EMPTY_FLAG_N,
    input  wire logic                       ALMOST_EMPTY_FLAG_N,
    input  wire logic                       ALMOST_FULL_FLAG_N,
    input  wire logic                       FULL_FLAG_N,
    input  wire logic                       DUAL_ENABLE_MODE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    wire go = CE && MASTER_RESET_N; // Edge where transfers may be taken
    wire load_pin = WRITE_ENABLE_B_OR_OFFSET_LOAD; // Second enable or load pin

    chk_mreset_flags: assert property (CE && !MASTER_RESET_N |=> !EMPTY_FLAG_N &&
        !ALMOST_EMPTY_FLAG_N && ALMOST_FULL_FLAG_N && FULL_FLAG_N)
        else $error("flags wrong after master reset");
    chk_mode_dual: assert property ((CE && !MASTER_RESET_N && load_pin) ##1 go |=>
        DUAL_ENABLE_MODE) else $error("dual mode not taken");
    chk_mode_prog: assert property ((CE && !MASTER_RESET_N && !load_pin) ##1 go |=>
        !DUAL_ENABLE_MODE) else $error("flag mode not taken");
    chk_full_blocks: assert property (go && !FULL_FLAG_N && READ_ENABLE_A_N |=>
        !FULL_FLAG_N) else $error("full flag left without a read");
    chk_empty_holds: assert property (go && !EMPTY_FLAG_N && WRITE_ENABLE_A_N && load_pin
        |=> !EMPTY_FLAG_N && $stable(OUT_BUS)) else $error("read taken while empty");
    chk_write_fills: assert property (go && !EMPTY_FLAG_N && !WRITE_ENABLE_A_N && load_pin
        |=> EMPTY_FLAG_N) else $error("write did not clear empty");
    chk_dual_gate: assert property (go && DUAL_ENABLE_MODE && !EMPTY_FLAG_N && !load_pin
        |=> !EMPTY_FLAG_N) else $error("stored with second enable low");
    chk_read_frees: assert property (go && !FULL_FLAG_N && WRITE_ENABLE_A_N && load_pin &&
        !READ_ENABLE_A_N && !READ_ENABLE_B_N |=> FULL_FLAG_N) else $error("read not taken");
    chk_oe_follow: assert property (CE |=> OUT_BUS_OE == !$past(OUTPUT_ENABLE_N))
        else $error("output enable not followed");
    chk_ae_empty: assert property (!EMPTY_FLAG_N |-> !ALMOST_EMPTY_FLAG_N)
        else $error("almost empty high while empty");
    chk_af_full: assert property (!FULL_FLAG_N |-> !ALMOST_FULL_FLAG_N)
        else $error("almost full high while full");

    // Main scenarios reached
    cov_full: cover property (!FULL_FLAG_N);
    cov_prog: cover property (!DUAL_ENABLE_MODE && go);
    cov_drain: cover property (!FULL_FLAG_N ##1 FULL_FLAG_N);
endmodule : sfp_fifo_assertions

bind sfp_fifo sfp_fifo_assertions u_chk (.CLK(CLK), .RESETN(RESETN), .CE(CE),
    .MASTER_RESET_N(MASTER_RESET_N), .WRITE_ENABLE_A_N(WRITE_ENABLE_A_N),
    .WRITE_ENABLE_B_OR_OFFSET_LOAD(WRITE_ENABLE_B_OR_OFFSET_LOAD),
    .READ_ENABLE_A_N(READ_ENABLE_A_N), .READ_ENABLE_B_N(READ_ENABLE_B_N),
    .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .OUT_BUS(OUT_BUS), .OUT_BUS_OE(OUT_BUS_OE),
    .EMPTY_FLAG_N(EMPTY_FLAG_N), .ALMOST_EMPTY_FLAG_N(ALMOST_EMPTY_FLAG_N),
    .ALMOST_FULL_FLAG_N(ALMOST_FULL_FLAG_N), .FULL_FLAG_N(FULL_FLAG_N),
    .DUAL_ENABLE_MODE(DUAL_ENABLE_MODE));

// file: verification/tb_sfp_fifo.sv
// Directed pin-level bench for the FIFO port and flag logic.
// Assumes one shared clock; bus model resolves the three-state output.
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_sfp_fifo;
    localparam int unsigned DEPTH = 16; // Small depth keeps the run short
    localparam int unsigned OFS   = sfp_pkg::OFFSET_DEFAULT;
    logic       clk = 0, resetn = 0, mrn = 0, ce = 1, wa_n = 1, wb = 1, ra_n = 1;
    logic       rb_n = 1, oe_n = 0;
    logic [8:0] in_bus = 9'h000;
    logic [8:0] q, q_line; // Registered output and resolved bus
    logic       oe, empty_n, ae, af, full_n, dual;
    int         bad_count = 0, check_count = 0, cyc_count = 0, i;

    sfp_fifo #(.DEPTH(DEPTH), .ADDR_W(4)) dut (.CLK(clk), .RESETN(resetn), .CE(ce),
        .MASTER_RESET_N(mrn), .IN_BUS(in_bus), .WRITE_ENABLE_A_N(wa_n),
        .WRITE_ENABLE_B_OR_OFFSET_LOAD(wb), .READ_ENABLE_A_N(ra_n), .READ_ENABLE_B_N(rb_n),
        .OUTPUT_ENABLE_N(oe_n), .OUT_BUS(q), .OUT_BUS_OE(oe), .EMPTY_FLAG_N(empty_n),
        .ALMOST_EMPTY_FLAG_N(ae), .ALMOST_FULL_FLAG_N(af), .FULL_FLAG_N(full_n),
        .DUAL_ENABLE_MODE(dual));
    sfp_bus_model u_bus (.clk(clk), .out_bus(q), .out_bus_oe(oe), .bus_line(q_line));

    // 250 MHz clock
    always #2 clk = ~clk;

    // Hang guard: the sequence needs well under 400 cycles
    always @(posedge clk)
    begin
        cyc_count++;
        if (cyc_count == 2000)
        begin
            bad_count++;
            wrap_up();
        end
    end

    // One clock of pin activity, driven at the falling edge
    task automatic cyc(input logic a, input logic b, input logic r, input logic [8:0] d);
        @(negedge clk);
        wa_n = a;
        wb = b;
        ra_n = r;
        rb_n = r;
        in_bus = d;
        @(posedge clk);
        #1;
    endtask : cyc

    // Master reset with the load pin at the chosen level
    task automatic mr(input logic load_lvl);
        @(negedge clk);
        {mrn, wa_n, ra_n, rb_n, wb} = {1'b0, 1'b1, 1'b1, 1'b1, load_lvl};
        @(negedge clk);
        {mrn, wb} = 2'b11;
        @(posedge clk);
        #1;
    endtask : mr

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        @(negedge clk) resetn = 1;
        mr(1'b1);
        `CHK("dual", 1'b1, dual)
        `CHK("rst_flags", 4'b0011, {empty_n, ae, af, full_n})
        cyc(1, 1, 0, 9'h000);
        `CHK("q_empty", 9'h000, q)
        cyc(0, 0, 1, 9'h055);
        `CHK("empty_bgate", 1'b0, empty_n)
        // Fill to the brim, watching every flag threshold
        for (i = 0; i < DEPTH; i++)
        begin
            cyc(0, 1, 1, 9'h0a0 + 9'(i));
            `CHK("empty_n", 1'b1, empty_n)
            `CHK("ae", 1'((i + 1) > OFS), ae)
            `CHK("af", 1'((i + 1) < DEPTH - OFS), af)
            `CHK("full_n", 1'((i + 1) < DEPTH), full_n)
        end
        cyc(0, 1, 1, 9'h1ff);
        `CHK("full_refused", 1'b0, full_n)
        // Drain in order; the refused word must never appear
        for (i = 0; i < DEPTH; i++)
        begin
            cyc(1, 1, 0, 9'h000);
            `CHK("q", 9'h0a0 + 9'(i), q)
            `CHK("full_rd", 1'b1, full_n)
        end
        cyc(1, 1, 0, 9'h000);
        `CHK("q_refused", 9'h0a0 + 9'(DEPTH - 1), q)
        `CHK("empty_drained", 1'b0, empty_n)
        // Output enable lags its pin by one edge, so give it a whole cycle
        @(negedge clk) oe_n = 1'b1;
        cyc(1, 1, 1, 9'h000);
        `CHK("oe_off", 1'b0, oe)
        `CHK("bus_off", ~(9'h0a0 + 9'(DEPTH - 1)), q_line)
        @(negedge clk) oe_n = 1'b0;
        cyc(1, 1, 1, 9'h000);
        `CHK("oe_on", 1'b1, oe)
        `CHK("bus_on", 9'h0a0 + 9'(DEPTH - 1), q_line)
        // Clock enable low freezes the block: a write offered then is lost
        @(negedge clk) ce = 1'b0;
        cyc(0, 1, 1, 9'h0aa);
        cyc(1, 1, 1, 9'h000);
        @(negedge clk) ce = 1'b1;
        cyc(1, 1, 0, 9'h000);
        `CHK("ce_frozen", 1'b0, empty_n)
        `CHK("ce_q", 9'h0a0 + 9'(DEPTH - 1), q)
        // Flag mode: load pin held low for offset writes and readback
        mr(1'b0);
        `CHK("prog", 1'b0, dual)
        cyc(0, 0, 1, 9'h003);
        cyc(0, 0, 1, 9'h005);
        cyc(1, 0, 0, 9'h000);
        `CHK("ofs_e", 9'h003, q)
        cyc(1, 0, 0, 9'h000);
        `CHK("ofs_f", 9'h005, q)
        `CHK("empty_ofs", 1'b0, empty_n)
        for (i = 0; i < 5; i++)
        begin
            cyc(0, 1, 1, 9'(i));
            `CHK("ae_p", 1'((i + 1) > 3), ae)
        end
        // Only one read enable low: no word may leave
        @(negedge clk) {wa_n, ra_n, rb_n} = 3'b101;
        @(posedge clk);
        #1;
        `CHK("q_one_en", 9'h005, q)
        cyc(1, 1, 0, 9'h000);
        `CHK("q_p", 9'h000, q)
        wrap_up();
    end
endmodule : tb_sfp_fifo
